/* rtl/reset_boot_strap_control.sv */
// reset_boot_strap_control: reset pin filter, boot and mode straps,
// debug pin multiplexing and data port activity indicators.
// assumes the host pins arrive synchronous to i_sys_clk.
//
// How it works
// RULE1 - reset only after pin low over 50 ms
// RULE2 - host holds reset low at least 50 ms
// RULE3 - reset pin active low, pulled up when undriven
// RULE4 - boot strap low flash, high rom, pulled down
// RULE5 - mode strap low debug, high normal, pulled up
// RULE6 - clock pin debug clock or gpio a1
// RULE7 - data pin debug data or gpio a0
// RULE8 - both serial ports 115200 baud 8N1
// RULE9 - tx indicator low while data port sends
// RULE10 - rx indicator low while data port receives
// RULE11 - burn-in: reset low, boot high, release, boot low
// RULE12 - boot stays high across reset rising edge
// RULE13 - boot strap latched at reset release
// RULE14 - mode strap latched at reset release, held
`default_nettype none
module reset_boot_strap_control
#(
    parameter int unsigned RST_LOW_CYCLES = rbs_pkg::RST_LOW_CYCLES
)
(
    input  wire logic               i_sys_clk,
    input  wire logic               i_rstn,
    input  wire rbs_pkg::strap_pins_t i_straps,
    // serial-wire clock pin (debug clock or gpio a1)
    input  wire logic               i_swclk_pin_in,
    output logic                    o_swclk_pin_out,
    output logic                    o_swclk_pin_oe,
    // serial-wire data pin (debug data or gpio a0)
    input  wire logic               i_serial_wire_data_pin_in,
    output logic                    o_serial_wire_data_pin_out,
    output logic                    o_serial_wire_data_pin_oe,
    // debug core side
    input  wire rbs_pkg::pin_drive_t i_dbg_data_drive,
    output logic                    o_dbg_clk,
    output logic                    o_dbg_data_in,
    // gpio side
    input  wire rbs_pkg::pin_drive_t i_gpio_line_a1_drive,
    input  wire rbs_pkg::pin_drive_t i_gpio_line_a0_drive,
    output logic                    o_gpio_line_a1_in,
    output logic                    o_gpio_line_a0_in,
    // serial ports: core lines and pins
    input  wire logic               i_core_data_tx,
    input  wire logic               i_core_debug_tx,
    input  wire logic               i_data_port_receive,
    input  wire logic               i_debug_port_receive,
    output logic                    o_data_port_transmit,
    output logic                    o_debug_port_transmit,
    output logic                    o_core_data_rx,
    output logic                    o_core_debug_rx,
    output logic                    o_tx_activity_indicator_n,
    output logic                    o_rx_activity_indicator_n,
    // core control and status
    output logic                    o_core_reset,
    output logic                    o_boot_from_rom,
    output logic                    o_debug_mode
);
    import rbs_pkg::*;

    if (RST_LOW_CYCLES < 1 || RST_LOW_CYCLES >= (1 << RST_CNT_W))
    begin : g_chk
        $error("RST_LOW_CYCLES out of range");
    end

    localparam logic [RST_CNT_W-1:0] RST_LIMIT = RST_CNT_W'(RST_LOW_CYCLES);

    // effective pin levels, undriven pins take their pull
    logic rst_level;
    logic boot_level;
    logic mode_level;

    assign rst_level  = i_straps.rst_drv  ? i_straps.rst_low : RST_PIN_PULL;  // [RULE3]
    assign boot_level = i_straps.boot_drv ? i_straps.boot    : BOOT_PIN_PULL; // [RULE4]
    assign mode_level = i_straps.mode_drv ? i_straps.mode    : MODE_PIN_PULL; // [RULE5]

    // reset filter and strap capture
    rst_state_t           state_r;
    rst_state_t           state_nxt;
    logic [RST_CNT_W-1:0] cnt_r;
    logic [RST_CNT_W-1:0] cnt_nxt;
    logic                 boot_r;
    logic                 boot_nxt;
    logic                 mode_r;
    logic                 mode_nxt;

    // starts held so straps are caught when the pin is first seen high
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        boot_nxt  = boot_r;
        mode_nxt  = mode_r;
        case (state_r)
            ST_RUN:
            begin
                if (!rst_level)
                begin
                    state_nxt = ST_FILTER;
                    cnt_nxt   = RST_CNT_W'(1);
                end
            end
            ST_FILTER:
            begin
                // a short glitch returns to run with no effect
                if (rst_level)
                begin
                    state_nxt = ST_RUN;                  // [RULE1]
                    cnt_nxt   = '0;
                end
                else if (cnt_r >= RST_LIMIT)
                begin
                    state_nxt = ST_HELD;                 // [RULE1] [RULE2]
                end
                else
                begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_HELD:
            begin
                // the release edge is the only moment the straps are looked at
                if (rst_level)
                begin
                    state_nxt = ST_RUN;
                    cnt_nxt   = '0;
                    boot_nxt  = boot_level;              // [RULE13] [RULE11] [RULE12]
                    mode_nxt  = mode_level;              // [RULE14]
                end
            end
            default:
            begin
                state_nxt = ST_HELD;
                cnt_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_r <= ST_HELD;
            cnt_r   <= '0;
            boot_r  <= BOOT_FLASH;
            mode_r  <= MODE_NORMAL;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            boot_r  <= boot_nxt;
            mode_r  <= mode_nxt;
        end
    end

    logic in_reset;
    logic dbg_sel;

    assign in_reset        = (state_r == ST_HELD);
    assign dbg_sel         = (mode_r == MODE_DEBUG);
    assign o_core_reset    = in_reset;                                     // [RULE1]
    assign o_boot_from_rom = (boot_r == BOOT_ROM);                         // [RULE4] [RULE13]
    assign o_debug_mode    = dbg_sel;                                      // [RULE5] [RULE14]

    // debug pin multiplexing; pins float while the core is held in reset
    pin_drive_t clk_pin_r;
    pin_drive_t clk_pin_nxt;
    pin_drive_t dat_pin_r;
    pin_drive_t dat_pin_nxt;

    always_comb
    begin
        clk_pin_nxt = '0;
        dat_pin_nxt = '0;
        if (!in_reset)
        begin
            if (dbg_sel)
            begin
                clk_pin_nxt = '0;                                          // [RULE6]
                dat_pin_nxt = i_dbg_data_drive;                            // [RULE7]
            end
            else
            begin
                clk_pin_nxt = i_gpio_line_a1_drive;                        // [RULE6]
                dat_pin_nxt = i_gpio_line_a0_drive;                        // [RULE7]
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            clk_pin_r <= '0;
            dat_pin_r <= '0;
        end
        else
        begin
            clk_pin_r <= clk_pin_nxt;
            dat_pin_r <= dat_pin_nxt;
        end
    end

    assign o_swclk_pin_out            = clk_pin_r.out;
    assign o_swclk_pin_oe             = clk_pin_r.oe;
    assign o_serial_wire_data_pin_out = dat_pin_r.out;
    assign o_serial_wire_data_pin_oe  = dat_pin_r.oe;

    // inputs of the unselected function are held at idle so neither side sees noise
    assign o_dbg_clk         = dbg_sel  && i_swclk_pin_in;                 // [RULE6]
    assign o_dbg_data_in     = dbg_sel  ? i_serial_wire_data_pin_in : 1'b1; // [RULE7]
    assign o_gpio_line_a1_in = !dbg_sel && i_swclk_pin_in;                 // [RULE6]
    assign o_gpio_line_a0_in = !dbg_sel && i_serial_wire_data_pin_in;      // [RULE7]

    // serial ports: lines pass through; format is fixed at 8N1 115200
    // tx lines held idle during reset so the far end sees no false start bit
    logic data_tx_r;
    logic data_tx_nxt;
    logic debug_tx_r;
    logic debug_tx_nxt;

    always_comb
    begin
        data_tx_nxt  = in_reset ? 1'b1 : i_core_data_tx;                   // [RULE8]
        debug_tx_nxt = in_reset ? 1'b1 : i_core_debug_tx;                  // [RULE8]
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            data_tx_r  <= 1'b1;
            debug_tx_r <= 1'b1;
        end
        else
        begin
            data_tx_r  <= data_tx_nxt;
            debug_tx_r <= debug_tx_nxt;
        end
    end

    assign o_data_port_transmit  = data_tx_r;
    assign o_debug_port_transmit = debug_tx_r;
    assign o_core_data_rx        = i_data_port_receive;
    assign o_core_debug_rx       = i_debug_port_receive;

    // activity indicators: busy for one 8N1 frame after each start bit
    logic tx_busy;
    logic rx_busy;

    serial_activity_detect
    #(
        .FRAME_CYCLES (UART_FRAME_CYCLES)
    )
    u_tx_act
    (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_line    (data_tx_r),
        .o_busy    (tx_busy)
    );

    serial_activity_detect
    #(
        .FRAME_CYCLES (UART_FRAME_CYCLES)
    )
    u_rx_act
    (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_line    (i_data_port_receive),
        .o_busy    (rx_busy)
    );

    assign o_tx_activity_indicator_n = tx_busy ? INDICATOR_ON : INDICATOR_OFF; // [RULE9]
    assign o_rx_activity_indicator_n = rx_busy ? INDICATOR_ON : INDICATOR_OFF; // [RULE10]
endmodule
`default_nettype wire

/* rtl/rbs_pkg.sv */
// rbs_pkg: shared constants and carrier types for the reset and boot strap block.
// assumes a 20 MHz system clock and pins already synchronous to it.
`default_nettype none
package rbs_pkg;
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS    = 50;
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned RST_LOW_MIN_MS   = 50;
    localparam int unsigned RST_LOW_MIN_NS   = RST_LOW_MIN_MS * 1_000_000;
    // least time: round up to whole cycles
    localparam int unsigned RST_LOW_CYCLES   =
        (RST_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_CNT_W        = 21;

    // serial format: 115200 baud, 8 data, no parity, 1 stop
    localparam int unsigned UART_BAUD        = 115200;
    localparam int unsigned UART_DATA_BITS   = 8;
    localparam int unsigned UART_STOP_BITS   = 1;
    localparam int unsigned UART_PARITY_BITS = 0;
    localparam int unsigned UART_FRAME_BITS  =
        1 + UART_DATA_BITS + UART_PARITY_BITS + UART_STOP_BITS;
    localparam int unsigned UART_BIT_CYCLES  = CLK_HZ / UART_BAUD;
    localparam int unsigned UART_FRAME_CYCLES = UART_FRAME_BITS * UART_BIT_CYCLES;
    localparam int unsigned ACT_CNT_W        = 12;

    // strap encodings and pull defaults of undriven pins
    localparam logic BOOT_FLASH        = 1'b0;
    localparam logic BOOT_ROM          = 1'b1;
    localparam logic MODE_DEBUG        = 1'b0;
    localparam logic MODE_NORMAL       = 1'b1;
    localparam logic RST_PIN_PULL      = 1'b1;
    localparam logic BOOT_PIN_PULL     = 1'b0;
    localparam logic MODE_PIN_PULL     = 1'b1;
    localparam logic INDICATOR_ON      = 1'b0;
    localparam logic INDICATOR_OFF     = 1'b1;

    // reset pin filter states, one-hot
    typedef enum logic [2:0] {
        ST_RUN    = 3'b001,
        ST_FILTER = 3'b010,
        ST_HELD   = 3'b100
    } rst_state_t;

    // host-facing strap pins: level plus a flag that the host drives it
    typedef struct packed {
        logic rst_low;
        logic rst_drv;
        logic boot;
        logic boot_drv;
        logic mode;
        logic mode_drv;
    } strap_pins_t;

    // one two-way pin as seen from the block
    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;
endpackage
`default_nettype wire

/* rtl/serial_activity_detect.sv */
// serial_activity_detect: flags a serial line busy for one whole frame.
// assumes an idle-high line sampled on the system clock.
`default_nettype none
module serial_activity_detect
#(
    parameter int unsigned FRAME_CYCLES = rbs_pkg::UART_FRAME_CYCLES
)
(
    input  wire logic i_sys_clk,
    input  wire logic i_rstn,
    input  wire logic i_line,
    output logic      o_busy
);
    import rbs_pkg::*;

    if (FRAME_CYCLES < 1 || FRAME_CYCLES >= (1 << ACT_CNT_W))
    begin : g_chk
        $error("FRAME_CYCLES out of range");
    end

    localparam logic [ACT_CNT_W-1:0] FRAME_LOAD = ACT_CNT_W'(FRAME_CYCLES);

    logic                 line_r;
    logic                 line_nxt;
    logic [ACT_CNT_W-1:0] cnt_r;
    logic [ACT_CNT_W-1:0] cnt_nxt;

    // a falling edge is a start bit; it reloads so back-to-back frames stay busy
    always_comb
    begin
        line_nxt = i_line;
        cnt_nxt  = cnt_r;
        if (line_r && !i_line)
        begin
            cnt_nxt = FRAME_LOAD;
        end
        else if (cnt_r != '0)
        begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            line_r <= 1'b1;
            cnt_r  <= '0;
        end
        else
        begin
            line_r <= line_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    assign o_busy = (cnt_r != '0);
endmodule
`default_nettype wire

/* tb/rbs_props.sv */
// rbs_props: port checks of reset_boot_strap_control, bound from the bench top.
// assumes one clock domain and straps already synchronous to it.
`default_nettype none
module rbs_props
    import rbs_pkg::*;
#(
    parameter int unsigned RST_LOW_CYCLES = 20
)
(
    input wire logic        i_sys_clk,
    input wire logic        i_rstn,
    input wire strap_pins_t i_straps,
    input wire logic        i_swclk_pin_in,
    input wire logic        o_swclk_pin_out,
    input wire logic        o_swclk_pin_oe,
    input wire logic        i_serial_wire_data_pin_in,
    input wire logic        o_serial_wire_data_pin_out,
    input wire logic        o_serial_wire_data_pin_oe,
    input wire pin_drive_t  i_dbg_data_drive,
    input wire logic        o_dbg_clk,
    input wire logic        o_dbg_data_in,
    input wire pin_drive_t  i_gpio_line_a1_drive,
    input wire pin_drive_t  i_gpio_line_a0_drive,
    input wire logic        o_gpio_line_a1_in,
    input wire logic        o_gpio_line_a0_in,
    input wire logic        i_core_data_tx,
    input wire logic        i_data_port_receive,
    input wire logic        o_data_port_transmit,
    input wire logic        o_core_data_rx,
    input wire logic        o_tx_activity_indicator_n,
    input wire logic        o_rx_activity_indicator_n,
    input wire logic        o_core_reset,
    input wire logic        o_boot_from_rom,
    input wire logic        o_debug_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        pin_low;
    logic [21:0] low_cnt_r;
    logic        rx_prev_r;
    logic [11:0] rx_age_r;
    // an undriven reset pin reads as its pull-up, never as low
    assign pin_low = i_straps.rst_drv & ~i_straps.rst_low;
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            low_cnt_r <= '0;
            rx_prev_r <= 1'b1;
            rx_age_r  <= '0;
        end
        else
        begin
            low_cnt_r <= pin_low ? low_cnt_r + 22'h1 : '0;
            rx_prev_r <= i_data_port_receive;
            if (rx_prev_r & ~i_data_port_receive)
                rx_age_r <= 12'h1;
            else if (rx_age_r != '0 && rx_age_r != 12'hFFF)
                rx_age_r <= rx_age_r + 12'h1;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_norm2;
        (!o_core_reset && !o_debug_mode) [*2];
    endsequence
    sequence s_dbg2;
        (!o_core_reset && o_debug_mode) [*2];
    endsequence
    a_short_ignored: assert property ($rose(o_core_reset)
        |-> low_cnt_r >= RST_LOW_CYCLES)
        else $error("core reset rose after a short low pulse");
    a_long_resets: assert property (low_cnt_r >= RST_LOW_CYCLES + 2 |-> o_core_reset)
        else $error("long low pulse gave no core reset");
    a_release_run: assert property (o_core_reset && !pin_low |-> ##[1:2] !o_core_reset)
        else $error("core reset held with reset pin high");
    a_straps_held: assert property (!o_core_reset && !$past(o_core_reset)
        |-> $stable(o_boot_from_rom) && $stable(o_debug_mode))
        else $error("boot or mode changed outside reset release");
    a_clk_pin_dbg: assert property (o_debug_mode |-> !o_swclk_pin_oe)
        else $error("clock pin driven in debug mode");
    a_clk_pin_gpio: assert property (s_norm2
        |-> {o_swclk_pin_out, o_swclk_pin_oe} == $past(i_gpio_line_a1_drive))
        else $error("clock pin does not follow gpio a1");
    a_data_pin_gpio: assert property (s_norm2
        |-> {o_serial_wire_data_pin_out, o_serial_wire_data_pin_oe}
            == $past(i_gpio_line_a0_drive))
        else $error("data pin does not follow gpio a0");
    a_data_pin_dbg: assert property (s_dbg2
        |-> {o_serial_wire_data_pin_out, o_serial_wire_data_pin_oe} == $past(i_dbg_data_drive))
        else $error("data pin does not follow debug drive");
    a_pin_inputs: assert property (o_debug_mode
        ? (o_dbg_clk == i_swclk_pin_in && o_dbg_data_in == i_serial_wire_data_pin_in)
        : (o_gpio_line_a1_in == i_swclk_pin_in && o_gpio_line_a0_in == i_serial_wire_data_pin_in))
        else $error("pin level routed to the wrong function");
    // the transmit line is held idle while the core sits in reset
    a_data_port_copy: assert property ($past(i_rstn)
        |-> o_data_port_transmit == ($past(o_core_reset) ? 1'b1 : $past(i_core_data_tx))
            && o_core_data_rx == i_data_port_receive)
        else $error("data port lines not passed through");
    a_tx_activity: assert property ($fell(o_data_port_transmit)
        |=> !o_tx_activity_indicator_n)
        else $error("tx indicator not lit after start bit");
    a_rx_frame: assert property (rx_age_r inside {[1:UART_FRAME_CYCLES]}
        |-> !o_rx_activity_indicator_n)
        else $error("rx indicator dark within a frame");
    a_rx_idle: assert property (rx_age_r == UART_FRAME_CYCLES + 1
        |-> o_rx_activity_indicator_n)
        else $error("rx indicator lit after the frame");
endmodule
`default_nettype wire

/* tb/host_model.sv */
// host_model: host side of reset, boot and mode straps and a data port sender.
// assumes tasks are called from the bench; every change lands on a falling edge.
`default_nettype none
module host_model
(
    input  wire logic               i_sys_clk,
    output var rbs_pkg::strap_pins_t o_pins,
    output logic                    o_data_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    import rbs_pkg::*;
    // released straps sit at their pull levels
    initial o_pins = 6'h22;
    initial o_data_rx = 1'b1;
    task automatic set_mode(input logic drv, input logic lvl);
        @(negedge i_sys_clk);
        o_pins.mode_drv = drv;
        o_pins.mode     = drv ? lvl : MODE_PIN_PULL;
    endtask
    // burn selects the boot order: low, boot high, release, boot low
    task automatic reset_pulse(input int n, input logic burn);
        @(negedge i_sys_clk);
        o_pins.rst_drv = 1'b1;
        o_pins.rst_low = 1'b0;
        repeat (2) @(negedge i_sys_clk);
        if (burn)
        begin
            o_pins.boot_drv = 1'b1;
            o_pins.boot     = BOOT_ROM;
        end
        repeat (n) @(negedge i_sys_clk);
        o_pins.rst_drv = 1'b0;
        o_pins.rst_low = RST_PIN_PULL;
        repeat (3) @(negedge i_sys_clk);
        o_pins.boot_drv = 1'b0;
        o_pins.boot     = BOOT_PIN_PULL;
    endtask
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int k = 0; k < 10; k++)
        begin
            o_data_rx = frame[k];
            repeat (UART_BIT_CYCLES) @(negedge i_sys_clk);
        end
    endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// testbench: directed checks of reset_boot_strap_control against a host model.
// assumes a shortened reset filter count so the run stays short.
`default_nettype none
module testbench
    import rbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned LIM = 20;
    // the tests need about 1,900 cycles; the rest is slack
    localparam int unsigned TIMEOUT_CYCLES = 6000;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    strap_pins_t i_straps;
    pin_drive_t i_dbg_data_drive, i_gpio_line_a1_drive, i_gpio_line_a0_drive;
    logic i_swclk_pin_in, i_serial_wire_data_pin_in, ext_clk, ext_data;
    logic i_core_data_tx, i_core_debug_tx, i_data_port_receive, i_debug_port_receive;
    logic o_swclk_pin_out, o_swclk_pin_oe, o_serial_wire_data_pin_out, o_serial_wire_data_pin_oe;
    logic o_dbg_clk, o_dbg_data_in, o_gpio_line_a1_in, o_gpio_line_a0_in;
    logic o_data_port_transmit, o_debug_port_transmit, o_core_data_rx, o_core_debug_rx;
    logic o_tx_activity_indicator_n, o_rx_activity_indicator_n;
    logic o_core_reset, o_boot_from_rom, o_debug_mode;
    int   fail_count = 0;
    int   total_checks = 0;
    int   cycles = 0;
    int   rst_cycles = 0;
    int   rst_base;
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("[FAIL] %0t mismatch got %b exp %b", $time, got, exp); \
        end \
    end
    // wire level: the block wins while it drives, the bench elsewhere
    assign i_swclk_pin_in = o_swclk_pin_oe ? o_swclk_pin_out : ext_clk;
    assign i_serial_wire_data_pin_in = o_serial_wire_data_pin_oe ? o_serial_wire_data_pin_out
                                                                 : ext_data;
    reset_boot_strap_control #(.RST_LOW_CYCLES(LIM)) reset_boot_strap_control_i (.*);
    host_model host_model_i
    (
        .i_sys_clk (i_sys_clk),
        .o_pins    (i_straps),
        .o_data_rx (i_data_port_receive)
    );
    always #25 i_sys_clk = ~i_sys_clk;
    // cycles spent in core reset; tests compare it before and after a pulse
    always @(posedge i_sys_clk)
    begin
        if (o_core_reset)
            rst_cycles++;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        {i_dbg_data_drive, i_gpio_line_a1_drive, i_gpio_line_a0_drive} = 6'h00;
        {ext_clk, ext_data} = 2'b00;
        {i_core_data_tx, i_core_debug_tx, i_debug_port_receive} = 3'h7;
        fork
            begin
                repeat (4) @(negedge i_sys_clk);
                i_rstn = 1'b1;
                repeat (3) @(negedge i_sys_clk);
                `CHK(o_core_reset, 1'b0)
                `CHK(o_boot_from_rom, BOOT_FLASH)
                `CHK(o_debug_mode, 1'b0)
                rst_base = rst_cycles;
                host_model_i.reset_pulse(LIM - 2, 1'b0);
                `CHK(rst_cycles == rst_base, 1'b1)
                rst_base = rst_cycles;
                host_model_i.reset_pulse(LIM + 2, 1'b1);
                `CHK(rst_cycles > rst_base, 1'b1)
                `CHK(o_core_reset, 1'b0)
                `CHK(o_boot_from_rom, 1'b1)
                host_model_i.set_mode(1'b1, MODE_DEBUG);
                host_model_i.reset_pulse(LIM + 2, 1'b0);
                host_model_i.set_mode(1'b0, 1'b0);
                i_dbg_data_drive = 2'h3;
                i_gpio_line_a0_drive = 2'h1;
                i_gpio_line_a1_drive = 2'h3;
                // clock pin high from outside, so the debug clock input must show it
                {ext_clk, ext_data} = 2'b10;
                repeat (2) @(negedge i_sys_clk);
                `CHK(o_boot_from_rom, 1'b0)
                `CHK(o_debug_mode, 1'b1)
                `CHK(i_serial_wire_data_pin_in, 1'b1)
                `CHK(o_swclk_pin_oe, 1'b0)
                `CHK(o_dbg_clk, 1'b1)
                `CHK(o_gpio_line_a1_in, 1'b0)
                {ext_clk, ext_data} = 2'b01;
                host_model_i.reset_pulse(LIM + 2, 1'b0);
                `CHK(o_debug_mode, 1'b0)
                `CHK(i_serial_wire_data_pin_in, 1'b0)
                `CHK(i_swclk_pin_in, 1'b1)
                `CHK(o_gpio_line_a1_in, 1'b1)
                `CHK(o_dbg_data_in, 1'b1)
                {i_core_data_tx, i_core_debug_tx, i_debug_port_receive} = 3'h0;
                repeat (3) @(negedge i_sys_clk);
                `CHK(o_tx_activity_indicator_n, INDICATOR_ON)
                `CHK(o_debug_port_transmit, 1'b0)
                `CHK(o_core_debug_rx, 1'b0)
                {i_core_data_tx, i_core_debug_tx, i_debug_port_receive} = 3'h7;
                // one falling edge per frame, so the frame length alone decides the indicator
                fork
                    host_model_i.send_byte(8'hF0);
                    begin
                        repeat (5) @(negedge i_sys_clk);
                        `CHK(o_rx_activity_indicator_n, INDICATOR_ON)
                        `CHK(o_core_data_rx, 1'b0)
                    end
                join
                repeat (10) @(negedge i_sys_clk);
                `CHK(o_rx_activity_indicator_n, INDICATOR_OFF)
                `CHK(o_tx_activity_indicator_n, INDICATOR_OFF)
                // core lines low through reset: the pins must still idle high
                {i_core_data_tx, i_core_debug_tx} = 2'b00;
                i_rstn = 1'b0;
                repeat (2) @(negedge i_sys_clk);
                `CHK(o_data_port_transmit, 1'b1)
                `CHK(o_debug_port_transmit, 1'b1)
                {i_core_data_tx, i_core_debug_tx} = 2'b11;
                i_rstn = 1'b1;
                repeat (3) @(negedge i_sys_clk);
                `CHK(o_core_reset, 1'b0)
                `CHK(o_boot_from_rom, BOOT_FLASH)
            end
            begin
                while (cycles < TIMEOUT_CYCLES)
                begin
                    @(posedge i_sys_clk);
                    cycles++;
                end
                fail_count++;
                $display("[FAIL] %0t timeout", $time);
            end
        join_any
        wrap_up();
    end
endmodule
bind reset_boot_strap_control rbs_props #(.RST_LOW_CYCLES(RST_LOW_CYCLES)) rbs_props_i (.*);
`default_nettype wire
